// ---- core/acc_consts.svh ----
// Offsets, field positions, reset values and timing counts of the converter control block.
// Assumes a 20 MHz system clock and a 32-bit classic Wishbone register bus.
//
// Contract
// - Power-on port config loads 0000 or 0111 by fuse
// - Timing bit 7 picks right or left justify
// - Acquisition codes map to 20..0 bit periods
// - Clock code 111 selects internal RC clock
// - Oscillator divisors 2..64 by code, x11 is RC
// - RC clock starts one instruction cycle late
// - Conversion lasts eleven bit periods, successive approximation
// - Reset restores registers, disables, aborts conversion
// - Completion loads result, clears go, sets flag
// - Power-on reset leaves result pair untouched
// - Programmed acquisition precedes conversion after go
// - Code 000 converts at once, else acquires first
// - Completion seen by polling go or by interrupt
// - Three bit periods between conversion and next acquisition
// - Sampling resumes after conversion, no acquisition status
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ACC_OFS_CTRL0      8'h00
`define ACC_OFS_CTRL1      8'h04
`define ACC_OFS_TFC        8'h08
`define ACC_OFS_RES_HIGH   8'h0c
`define ACC_OFS_RES_LOW    8'h10
`define ACC_OFS_IRQ        8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACC_CTRL0_ON       0
`define ACC_CTRL0_GO       1
`define ACC_CTRL0_CHAN     2
`define ACC_CTRL1_PORT_ANALOG_CONFIG_FIELD     0
`define ACC_CTRL1_VREF     4
`define ACC_TFC_JUSTIFY    7
`define ACC_TFC_ACQ        3
`define ACC_TFC_CLK        0
`define ACC_IRQ_FLAG       0
`define ACC_IRQ_IE         1
`define ACC_IRQ_GIE        2

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define ACC_PORT_ANALOG_CONFIG_FIELD_RST_ANALOG  4'h0
`define ACC_PORT_ANALOG_CONFIG_FIELD_RST_DIGITAL 4'h7
`define ACC_RESULT_BITS      10
`define ACC_CLK_HZ           20000000
`define ACC_TCY_NS           200
`define ACC_TCY_CYCLES       ((`ACC_TCY_NS * (`ACC_CLK_HZ / 1000000) + 999) / 1000)
`define ACC_CONV_TADS        11
`define ACC_GAP_TADS         3

`endif

// ---- core/acc_conv_if.sv ----
// Link between the sequencer and the successive-approximation engine.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps

interface acc_conv_if;
  import acc_pkg::*;
  logic      tad;
  logic      start;
  logic      abort;
  logic      comp;
  logic      busy;
  logic      done;
  acc_code_t result;
  acc_code_t dac;

  modport ctrl (output tad, start, abort, comp, input busy, done, result, dac);
  modport sar  (input tad, start, abort, comp, output busy, done, result, dac);
endinterface : acc_conv_if

// ---- core/acc_pkg.sv ----
// Types shared by the converter control modules.
// Assumes acc_consts.svh is on the include path.
`include "acc_consts.svh"

package acc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_ACQ, ST_CONV, ST_GAP} acc_state_e;
  typedef logic [`ACC_RESULT_BITS-1:0] acc_code_t;

  typedef struct packed {
    acc_state_e st;
    logic [4:0] tad_cnt;
    logic [2:0] dly_cnt;
    logic       on;
    logic       go;
    logic [3:0] chan;
    logic [3:0] port_analog_config_field;
    logic [1:0] vref;
    logic       justify;
    logic [2:0] acq;
    logic [2:0] clksel;
    logic       flag;
    logic       ie;
    logic       global_irq_enable;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic       ack;
    logic [31:0] rdata;
    logic       start;
    logic       abort;
  } acc_top_s;

  typedef struct packed {
    logic       busy;
    logic [3:0] cnt;
    acc_code_t  code;
    logic       done;
    acc_code_t  result;
  } acc_sar_s;

  typedef struct packed {
    logic [5:0] cnt;
    logic       tick;
  } acc_tad_s;
endpackage : acc_pkg

// ---- core/acc_sar.sv ----
// Successive-approximation engine: one bit period to disconnect, then one per bit.
// Assumes comp is high when the held input is at or above the trial code.
`timescale 1ns/1ps
`include "acc_consts.svh"

module acc_sar import acc_pkg::*; #(
  parameter int RES_BITS = `ACC_RESULT_BITS
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  acc_conv_if.sar   cv
);
  acc_sar_s s, next;

  if (RES_BITS != `ACC_RESULT_BITS) begin : g_chk
    $error("acc_sar: result width must match the state layout");
  end

  always_comb begin
    logic [3:0] b;
    acc_code_t  c;
    b         = 4'(RES_BITS) - s.cnt;
    c         = s.code;
    next      = s;
    next.done = 1'b0;
    if (sys_rst_i || cv.abort) begin
      next.busy = 1'b0;
      next.cnt  = '0;
      next.code = '0;
    end else if (cv.start && !s.busy) begin
      next.busy = 1'b1;
      next.cnt  = '0;
      next.code = '0;
    end else if (s.busy && cv.tad) begin
      if (s.cnt == 4'h0) begin
        c[RES_BITS-1] = 1'b1;
      end else begin
        if (!cv.comp) begin
          c[b] = 1'b0;
        end
        if (b != 4'h0) begin
          c[b - 4'h1] = 1'b1;
        end
      end
      next.code = c;
      next.cnt  = s.cnt + 4'h1;
      if (s.cnt == 4'(RES_BITS)) begin
        next.busy   = 1'b0;
        next.done   = 1'b1;
        next.result = c;
      end
    end
    if (sys_rst_i) begin
      next.result = s.result;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next;
  end

  assign cv.busy   = s.busy;
  assign cv.done   = s.done;
  assign cv.result = s.result;
  assign cv.dac    = s.code;
endmodule : acc_sar

// ---- core/acc_tad_gen.sv ----
// Bit-period enable generator: divides the system clock or passes RC ticks.
// Assumes rc_tick_i is a one-cycle pulse synchronous to clk_i.
`timescale 1ns/1ps

module acc_tad_gen import acc_pkg::*; (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [2:0] clk_sel_i,
  input  wire logic       rc_tick_i,
  // Bit-period pulse
  output logic            tad_o
);
  acc_tad_s s, next;

  function automatic logic [6:0] div_of(logic [2:0] c);
    unique case (c)
      3'h0:    div_of = 7'h02;
      3'h4:    div_of = 7'h04;
      3'h1:    div_of = 7'h08;
      3'h5:    div_of = 7'h10;
      3'h2:    div_of = 7'h20;
      3'h6:    div_of = 7'h40;
      default: div_of = 7'h00; // x11 is RC
    endcase
  endfunction : div_of

  always_comb begin
    next      = s;
    next.tick = 1'b0;
    if (sys_rst_i || !run_i) begin
      next = '0;
    end else if (clk_sel_i[1:0] == 2'h3) begin
      // Free-running RC: the first tick after start only opens the first full period
      if (rc_tick_i) begin
        next.cnt  = 6'h01;
        next.tick = s.cnt != 6'h00;
      end
    end else if ({1'b0, s.cnt} == div_of(clk_sel_i) - 7'h01) begin
      next.cnt  = '0;
      next.tick = 1'b1;
    end else begin
      next.cnt = s.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next;
  end

  assign tad_o = s.tick;
endmodule : acc_tad_gen

// ---- core/acc_top.sv ----
// Converter control: registers, acquisition and conversion sequencing, completion flag.
// Assumes a classic Wishbone master and an analog front end with comparator output.
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "acc_consts.svh"

module acc_top import acc_pkg::*; #(
  parameter int TCY_CYCLES = `ACC_TCY_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Configuration strap
  input  wire logic        portb_analog_default_fuse_i,
  // Analog front end
  input  wire logic        rc_tick_i,
  input  wire logic        comp_i,
  output logic             sample_o,
  output logic      [9:0]  dac_code_o,
  output logic      [3:0]  chan_sel_o,
  output logic      [3:0]  port_analog_config_o,
  output logic      [1:0]  vref_sel_o,
  // Interrupt request
  output logic             irq_o
);
  acc_top_s   s, next;
  acc_conv_if cv ();
  logic       bus_req;
  logic       rc_sel;
  logic       tad_run;

  if (TCY_CYCLES < 1 || TCY_CYCLES > 7) begin : g_chk
    $error("acc_top: TCY_CYCLES must be 1..7");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] acq_tads(logic [2:0] c);
    unique case (c)
      3'h7: acq_tads = 5'h14;
      3'h6: acq_tads = 5'h10;
      3'h5: acq_tads = 5'h0c;
      3'h4: acq_tads = 5'h08;
      3'h3: acq_tads = 5'h06;
      3'h2: acq_tads = 5'h04;
      3'h1: acq_tads = 5'h02;
      3'h0: acq_tads = 5'h00;
    endcase
  endfunction : acq_tads

  function automatic logic [31:0] read_word(acc_top_s r, logic [7:0] a);
    logic [31:0] w;
    w = '0;
    case (a)
      `ACC_OFS_CTRL0: begin
        w[`ACC_CTRL0_ON]        = r.on;
        w[`ACC_CTRL0_GO]        = r.go;
        w[`ACC_CTRL0_CHAN +: 4] = r.chan;
      end
      `ACC_OFS_CTRL1: begin
        w[`ACC_CTRL1_PORT_ANALOG_CONFIG_FIELD +: 4] = r.port_analog_config_field;
        w[`ACC_CTRL1_VREF +: 2] = r.vref;
      end
      `ACC_OFS_TFC: begin
        w[`ACC_TFC_JUSTIFY]    = r.justify; // bit 6 stays zero
        w[`ACC_TFC_ACQ +: 3]   = r.acq;
        w[`ACC_TFC_CLK +: 3]   = r.clksel;
      end
      `ACC_OFS_RES_HIGH: w[7:0] = r.res_hi;
      `ACC_OFS_RES_LOW:  w[7:0] = r.res_lo;
      `ACC_OFS_IRQ: begin
        w[`ACC_IRQ_FLAG] = r.flag;
        w[`ACC_IRQ_IE]   = r.ie;
        w[`ACC_IRQ_GIE]  = r.global_irq_enable;
      end
      default: w = '0;
    endcase
    return w;
  endfunction : read_word

  assign bus_req = wb_cyc_i && wb_stb_i && !s.ack;
  assign rc_sel  = s.clksel[1:0] == 2'h3;
  assign tad_run = s.st == ST_ACQ || s.st == ST_CONV || s.st == ST_GAP;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next       = s;
    next.ack   = 1'b0;
    next.start = 1'b0;
    next.abort = 1'b0;

    // Register access; unmapped offsets answer with zero and drop writes
    if (bus_req) begin
      next.ack   = 1'b1;
      next.rdata = read_word(s, wb_adr_i);
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          `ACC_OFS_CTRL0: begin
            next.on   = wb_dat_i[`ACC_CTRL0_ON];
            next.chan = wb_dat_i[`ACC_CTRL0_CHAN +: 4];
            if (wb_dat_i[`ACC_CTRL0_GO] && wb_dat_i[`ACC_CTRL0_ON]) begin
              next.go = 1'b1;
            end
          end
          `ACC_OFS_CTRL1: begin
            next.port_analog_config_field = wb_dat_i[`ACC_CTRL1_PORT_ANALOG_CONFIG_FIELD +: 4];
            next.vref = wb_dat_i[`ACC_CTRL1_VREF +: 2];
          end
          `ACC_OFS_TFC: begin
            next.justify = wb_dat_i[`ACC_TFC_JUSTIFY]; // bit 6 dropped
            next.acq     = wb_dat_i[`ACC_TFC_ACQ +: 3];
            next.clksel  = wb_dat_i[`ACC_TFC_CLK +: 3];
          end
          `ACC_OFS_IRQ: begin
            next.flag = wb_dat_i[`ACC_IRQ_FLAG];
            next.ie   = wb_dat_i[`ACC_IRQ_IE];
            next.global_irq_enable  = wb_dat_i[`ACC_IRQ_GIE];
          end
          default: ;
        endcase
      end
    end

    // Sequencer
    unique case (s.st)
      ST_IDLE: begin
        if (s.go && s.on) begin
          next.tad_cnt = '0;
          next.dly_cnt = '0;
          if (rc_sel) begin
            next.st = ST_DELAY;
          end else if (s.acq != 3'h0) begin
            next.st = ST_ACQ;
          end else begin
            next.st    = ST_CONV;
            next.start = 1'b1;
          end
        end
      end
      ST_DELAY: begin
        next.dly_cnt = s.dly_cnt + 3'h1;
        if (s.dly_cnt == 3'(TCY_CYCLES - 1)) begin
          if (s.acq != 3'h0) begin
            next.st = ST_ACQ;
          end else begin
            next.st    = ST_CONV;
            next.start = 1'b1;
          end
        end
      end
      ST_ACQ: begin
        if (cv.tad) begin
          next.tad_cnt = s.tad_cnt + 5'h01;
          if (s.tad_cnt + 5'h01 == acq_tads(s.acq)) begin
            next.st    = ST_CONV;
            next.start = 1'b1;
          end
        end
      end
      ST_CONV: begin
        if (cv.done) begin
          if (s.justify) begin
            next.res_hi = {6'h00, cv.result[9:8]};
            next.res_lo = cv.result[7:0];
          end else begin
            next.res_hi = cv.result[9:2];
            next.res_lo = {cv.result[1:0], 6'h00};
          end
          next.go      = 1'b0;
          next.flag    = 1'b1; // set wins over a clear
          next.st      = ST_GAP;
          next.tad_cnt = '0;
        end
      end
      ST_GAP: begin
        if (cv.tad) begin
          next.tad_cnt = s.tad_cnt + 5'h01;
          if (s.tad_cnt == 5'(`ACC_GAP_TADS - 1)) begin
            next.st = ST_IDLE;
          end
        end
      end
    endcase

    // Turning the converter off abandons any conversion
    if (!next.on) begin
      next.st    = ST_IDLE;
      next.go    = 1'b0;
      next.abort = 1'b1;
      next.start = 1'b0;
    end

    // Result pair is left alone so a reset never disturbs a read-back
    if (sys_rst_i) begin
      next        = '0;
      next.abort  = 1'b1;
      next.port_analog_config_field   = portb_analog_default_fuse_i ? `ACC_PORT_ANALOG_CONFIG_FIELD_RST_ANALOG
                                                : `ACC_PORT_ANALOG_CONFIG_FIELD_RST_DIGITAL;
      next.res_hi = s.res_hi;
      next.res_lo = s.res_lo;
    end
  end

  always_ff @(posedge clk_i) begin
    s <= next;
  end

  // ----------------------------------------------------------------
  // Submodules and outputs
  // ----------------------------------------------------------------
  acc_tad_gen u_tad (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .run_i     (tad_run),
    .clk_sel_i (s.clksel),
    .rc_tick_i (rc_tick_i),
    .tad_o     (cv.tad)
  );

  acc_sar u_sar (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .cv        (cv)
  );

  assign cv.start             = s.start;
  assign cv.abort             = s.abort;
  assign cv.comp              = comp_i;
  assign wb_dat_o             = s.rdata;
  assign wb_ack_o             = s.ack;
  assign dac_code_o           = cv.dac;
  assign chan_sel_o           = s.chan;
  assign port_analog_config_o = s.port_analog_config_field;
  assign vref_sel_o           = s.vref;
  assign sample_o             = s.on && s.st != ST_CONV;
  assign irq_o                = s.flag && s.ie && s.global_irq_enable;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [3:0] conv_tads;
  logic       idle_go;

  assign idle_go = s.st == ST_IDLE && s.go && s.on;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !cv.busy) begin
      conv_tads <= '0;
    end else if (cv.tad) begin
      conv_tads <= conv_tads + 4'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_irq_gate: assert property (irq_o |-> s.flag && s.ie && s.global_irq_enable)
    else $error("interrupt without flag and both enables");
  chk_done_effects: assert property (cv.done |=> !s.go && s.flag && s.st == ST_GAP)
    else $error("completion did not clear go and set flag");
  chk_right_justify: assert property (cv.done && s.justify
      |=> s.res_hi == {6'h00, $past(cv.result[9:8])} && s.res_lo == $past(cv.result[7:0]))
    else $error("right justified result wrong");
  chk_bit6_zero: assert property (bus_req && wb_adr_i == `ACC_OFS_TFC |=> wb_dat_o[6] == 1'b0)
    else $error("timing register bit 6 not zero");
  chk_manual_start: assert property (idle_go && s.acq == 3'h0 && !rc_sel |=> s.st == ST_CONV)
    else $error("manual acquisition did not convert at once");
  chk_acq_wait: assert property (idle_go && s.acq == 3'h1 && !rc_sel
      |=> (s.st == ST_ACQ)[*4])
    else $error("programmed acquisition cut short");
  chk_rc_delay: assert property (idle_go && rc_sel |=> (s.st == ST_DELAY)[*4])
    else $error("RC clock delay missing");
  chk_gap_hold: assert property (s.st == ST_CONV && cv.done |=> (s.st == ST_GAP)[*5])
    else $error("next acquisition too soon");
  chk_conv_len: assert property (cv.done |-> conv_tads == 4'(`ACC_CONV_TADS))
    else $error("conversion not eleven bit periods");
  chk_sample_resume: assert property ($fell(s.st == ST_CONV) && s.on |-> sample_o)
    else $error("sampling did not resume");
  chk_reset_state: assert property (disable iff (1'b0) sys_rst_i
      |=> s.st == ST_IDLE && !s.go && !s.on
          && s.port_analog_config_field == ($past(portb_analog_default_fuse_i) ? 4'h0 : 4'h7))
    else $error("reset state wrong");

  cov_manual: cover property (s.st == ST_IDLE ##1 s.st == ST_CONV ##[1:300] cv.done);
  cov_acq:    cover property (s.st == ST_ACQ ##[1:1000] cv.done);
  cov_rc:     cover property (s.st == ST_DELAY ##[1:1000] s.st == ST_CONV);
endmodule : acc_top

// ---- sim/acc_front_model.sv ----
// Behavioural analog front end: sample-and-hold, comparator and free-running RC tick.
// Assumes the converter drives sample_i high while the hold capacitor tracks the input.
`timescale 1ns/1ps

module acc_front_model #(
  parameter int RC_DIV = 10
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Converter side
  input  wire logic       sample_i,
  input  wire logic [9:0] dac_code_i,
  output logic            comp_o,
  output logic            rc_tick_o,
  // Analog level applied by the bench
  input  wire logic [9:0] level_i
);
  logic [9:0] held;
  int         rc_cnt;

  // ----------------------------------------------------------------
  // Hold keeps the last tracked level once the switch opens
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sample_i) begin
      held <= level_i;
    end
  end

  assign comp_o = (held >= dac_code_i);

  // ----------------------------------------------------------------
  // RC oscillator runs free, one pulse per bit period
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || rc_cnt == RC_DIV - 1) begin
      rc_cnt <= 0;
    end else begin
      rc_cnt <= rc_cnt + 1;
    end
  end

  assign rc_tick_o = (rc_cnt == RC_DIV - 1);
endmodule : acc_front_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the converter control block over classic Wishbone.
// Assumes the front-end model supplies comparator and RC ticks.
`timescale 1ns/1ps
`include "acc_consts.svh"

module tb_top;
  import acc_pkg::*;
  localparam int INSTR_CYC = 4;
  logic        clk_i, sys_rst_i, wb_cyc, wb_stb, wb_we, fuse, comp, rc_tick, sample, irq;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_dat_o, q;
  logic        wb_ack_o;
  logic [9:0]  dac, level;
  logic [3:0]  chan, port_analog_config_field;
  logic [1:0]  vref;
  int          miscompares, comparisons, tick, an, cn, t0, t1, d;
  int          divs [8] = '{2, 4, 8, 16, 32, 64, 10, 10};
  logic [2:0]  csel [8] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110, 3'b111, 3'b011};
  int          bits [8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  acc_top #(.TCY_CYCLES(INSTR_CYC)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .portb_analog_default_fuse_i(fuse),
    .rc_tick_i(rc_tick), .comp_i(comp), .sample_o(sample), .dac_code_o(dac),
    .chan_sel_o(chan), .port_analog_config_o(port_analog_config_field), .vref_sel_o(vref), .irq_o(irq));

  acc_front_model #(.RC_DIV(10)) front_model (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sample_i(sample), .dac_code_i(dac),
    .comp_o(comp), .rc_tick_o(rc_tick), .level_i(level));

  // ----------------------------------------------------------------
  // Clock, cycle count and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i) tick <= tick + 1;

  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task close_out();
    $display("Checked %0d, mismatched %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task wb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
    end
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb

  task wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] unused;
    wb(1'b1, a, wd, unused);
  endtask : wr

  task rst(input logic f);
    fuse      <= f;
    sys_rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask : rst

  // Cycles until the switch opens, then until it closes again
  task measure(output int a_n, output int c_n);
    a_n = 0;
    while (sample !== 1'b0 && a_n < 3000) begin
      @(posedge clk_i);
      a_n++;
    end
    c_n = 0;
    while (sample !== 1'b1 && c_n < 3000) begin
      @(posedge clk_i);
      c_n++;
    end
  endtask : measure

  task convert(input logic [2:0] acq, input logic [2:0] cs, input logic j, input logic [9:0] lv);
    int n;
    // Long settle covers any gap and the channel's acquisition need
    repeat (250) @(posedge clk_i);
    level <= lv;
    wr(`ACC_OFS_TFC, {24'h0, j, 1'b0, acq, cs});
    wr(`ACC_OFS_CTRL0, 32'h0000000f);
    measure(an, cn);
    q = 32'h2;
    n = 0;
    while (q[1] !== 1'b0 && n < 40) begin
      wb(1'b0, `ACC_OFS_CTRL0, 32'h0, q);
      n++;
    end
    check("go", 32'h0, {31'h0, q[1]});
    check("chan", 32'h3, {28'h0, chan});
    wb(1'b0, `ACC_OFS_IRQ, 32'h0, q);
    check("flag", 32'h1, {31'h0, q[0]});
    wb(1'b0, `ACC_OFS_RES_HIGH, 32'h0, q);
    check("res hi", j ? {30'h0, lv[9:8]} : {24'h0, lv[9:2]}, q);
    wb(1'b0, `ACC_OFS_RES_LOW, 32'h0, q);
    check("res lo", j ? {24'h0, lv[7:0]} : {24'h0, lv[1:0], 6'h0}, q);
  endtask : convert

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    fuse = 1'b1;
    level = 10'h000;
    rst(1'b1);
    wb(1'b0, `ACC_OFS_CTRL1, 32'h0, q);
    check("port_analog_config_field analog", 32'h0, q);
    check("port_analog_config_field pins", 32'h0, {28'h0, port_analog_config_field});
    wr(`ACC_OFS_CTRL1, 32'h0000003a);
    wb(1'b0, `ACC_OFS_CTRL1, 32'h0, q);
    check("ctrl1 rw", 32'h3a, q);
    check("port_analog_config_field set", 32'ha, {28'h0, port_analog_config_field});
    check("vref pins", 32'h3, {30'h0, vref});
    wb(1'b0, `ACC_OFS_TFC, 32'h0, q);
    check("timing rst", 32'h0, q);
    wb(1'b0, 8'h3c, 32'h0, q);
    check("unmapped", 32'h0, q);
    wr(`ACC_OFS_TFC, 32'h000000ff);
    wb(1'b0, `ACC_OFS_TFC, 32'h0, q);
    check("timing rw", 32'hbf, q);
    wr(`ACC_OFS_CTRL0, 32'h00000002);
    wb(1'b0, `ACC_OFS_CTRL0, 32'h0, q);
    check("go off", 32'h0, q);
    wr(`ACC_OFS_CTRL0, 32'h00000001);
    wr(`ACC_OFS_IRQ, 32'h00000006);
    for (int i = 0; i < 8; i++) begin
      d = divs[i];
      convert(3'b000, csel[i], i[0], 10'h2a5 + 10'(i * 83));
      check("conv len", 32'h1, {31'h0, (cn >= 11 * d && cn <= 12 * d + 8)});
      if (i >= 6) begin
        check("rc delay", 32'h1, {31'h0, (an + cn >= 11 * d + INSTR_CYC)});
      end else begin
        check("no acq", 32'h1, {31'h0, (an <= 6)});
      end
      check("irq", 32'h1, {31'h0, irq});
      wr(`ACC_OFS_IRQ, 32'h00000006);
    end
    for (int i = 1; i < 8; i++) begin
      convert(3'(i), 3'b000, 1'b1, 10'h155);
      check("acq len", 32'h1, {31'h0, (an >= bits[i] * 2 && an <= bits[i] * 2 + 8)});
    end
    for (int v = 0; v < 8; v++) begin
      wr(`ACC_OFS_IRQ, 32'(v));
      repeat (2) @(posedge clk_i);
      check("irq mix", {31'h0, v[0] & v[1] & v[2]}, {31'h0, irq});
      wb(1'b0, `ACC_OFS_IRQ, 32'h0, q);
      check("irq reg", 32'(v), q);
    end
    // Back-to-back go right after completion must wait out the gap
    wr(`ACC_OFS_TFC, 32'h00000001);
    wr(`ACC_OFS_CTRL0, 32'h0000000f);
    measure(an, cn);
    t0 = tick;
    wr(`ACC_OFS_CTRL0, 32'h0000000f);
    t1 = tick;
    measure(an, cn);
    check("gap", 32'h1, {31'h0, ((t1 - t0) + an >= 24 && (t1 - t0) + an <= 36)});
    repeat (400) @(posedge clk_i);
    wr(`ACC_OFS_IRQ, 32'h0);
    // Switching off mid-conversion abandons it
    wr(`ACC_OFS_TFC, 32'h00000006);
    wr(`ACC_OFS_CTRL0, 32'h00000003);
    repeat (100) @(posedge clk_i);
    wr(`ACC_OFS_CTRL0, 32'h0);
    wb(1'b0, `ACC_OFS_CTRL0, 32'h0, q);
    check("abort go", 32'h0, q);
    repeat (1000) @(posedge clk_i);
    wb(1'b0, `ACC_OFS_IRQ, 32'h0, q);
    check("abort flag", 32'h0, q);
    check("off sample", 32'h0, {31'h0, sample});
    rst(1'b0);
    wb(1'b0, `ACC_OFS_RES_HIGH, 32'h0, q);
    check("res kept", 32'h55, q);
    wb(1'b0, `ACC_OFS_CTRL1, 32'h0, q);
    check("port_analog_config_field digital", 32'h7, q);
    check("port_analog_config_field pins", 32'h7, {28'h0, port_analog_config_field});
    wb(1'b0, `ACC_OFS_TFC, 32'h0, q);
    check("timing rst", 32'h0, q);
    close_out();
  end
endmodule : tb_top
